// [src/port_host.sv]
/*
  Host end of the indirect parallel host port: an APB-programmed engine
  that runs whole write or read transactions through the pins, with a
  byte FIFO in the data path.
  Assumes an APB master on the same clock; the data bus pin is async.
*/
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "hostport_consts.svh"
module port_host #(
  parameter int PHASE_CYCLES = `PHASE_CYC,
  parameter int FIFO_DEPTH   = `FIFO_DEPTH
) (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  hostport_if.host         PINS
);
  hostport_pkg::host_state_e state_ff;
  logic [15:0] ofs_ff;
  logic [7:0]  blk_ff;
  logic [15:0] cnt_ff;
  logic        dir_rd_ff;
  logic [15:0] idx_ff;
  logic [7:0]  ph_ff;
  logic [7:0]  dmeta_ff;
  logic [7:0]  dsync_ff;
  logic [1:0]  sel_ff;
  logic [7:0]  dout_ff;
  logic        doe_ff;
  logic        csn_ff;
  logic        rdn_ff;
  logic        wrn_ff;

  // ========================================================================
  // FIFO in the data path, direction set by the transfer kind
  wire        f_in_ready;
  wire        f_out_valid;
  wire  [7:0] f_out_data;
  wire        acc       = PSEL & PENABLE & ~PREADY;
  wire        s_ctrl    = (PADDR == `REG_CTRL);
  wire        s_ofs     = (PADDR == `REG_OFFSET);
  wire        s_blk     = (PADDR == `REG_BLOCK);
  wire        s_cnt     = (PADDR == `REG_COUNT);
  wire        s_stat    = (PADDR == `REG_STATUS);
  wire        s_data    = (PADDR == `REG_DATA);
  wire        mapped    = s_ctrl | s_ofs | s_blk | s_cnt | s_stat | s_data;
  wire        busy      = (state_ff != hostport_pkg::H_IDLE);
  wire        apb_push  = acc & s_data & PWRITE & ~dir_rd_ff & f_in_ready;
  wire        apb_pop   = acc & s_data & ~PWRITE & dir_rd_ff & f_out_valid;
  wire        wait_wr   = s_data & PWRITE & ~dir_rd_ff & ~f_in_ready;
  wire        wait_rd   = s_data & ~PWRITE & dir_rd_ff & ~f_out_valid;
  wire        done_apb  = acc & ~wait_wr & ~wait_rd;
  wire        is_dat    = (idx_ff >= `SETUP_BYTES);
  wire        ph_end    = (ph_ff == 8'(PHASE_CYCLES - 1));
  wire        eng_pop   = (state_ff == hostport_pkg::H_SETUP) & is_dat & ~dir_rd_ff
                          & f_out_valid;
  wire        eng_push  = (state_ff == hostport_pkg::H_LOW) & ph_end & is_dat
                          & dir_rd_ff;
  wire        last_byte = (16'(idx_ff + 16'h0001) == 16'(cnt_ff + `SETUP_BYTES));
  wire [31:0] rd_mux    = s_ctrl ? {30'h0, dir_rd_ff, busy} :
                          s_ofs  ? {16'h0, ofs_ff} :
                          s_blk  ? {24'h0, blk_ff} :
                          s_cnt  ? {16'h0, cnt_ff} :
                          s_stat ? {29'h0, ~f_in_ready, ~f_out_valid, busy} :
                          s_data ? {24'h0, f_out_data} : 32'h0;

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (CLK),
    .rst_n     (RST_N),
    .in_valid  (dir_rd_ff ? eng_push : apb_push),
    .in_ready  (f_in_ready),
    .in_data   (dir_rd_ff ? dsync_ff : PWDATA[7:0]),
    .out_valid (f_out_valid),
    .out_ready (dir_rd_ff ? apb_pop : eng_pop),
    .out_data  (f_out_data)
  );

  // ========================================================================
  // APB slave, answer one cycle after the access phase opens and any DATA wait on a full or empty FIFO ends
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= '0;
    end else begin
      PREADY  <= done_apb;
      PSLVERR <= done_apb & ~mapped;
      PRDATA  <= (done_apb & ~PWRITE) ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ofs_ff    <= '0;
      blk_ff    <= '0;
      cnt_ff    <= '0;
      dir_rd_ff <= 1'b0;
    end else if (done_apb & PWRITE & ~busy) begin
      ofs_ff    <= s_ofs ? PWDATA[15:0] : ofs_ff;
      blk_ff    <= s_blk ? PWDATA[7:0] : blk_ff;
      cnt_ff    <= s_cnt ? PWDATA[15:0] : cnt_ff;
      dir_rd_ff <= s_ctrl ? PWDATA[`CTRL_READ] : dir_rd_ff;
    end
  end

  // ========================================================================
  // data bus synchroniser
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dmeta_ff <= '0;
      dsync_ff <= '0;
    end else begin
      dmeta_ff <= PINS.host_data_bus;
      dsync_ff <= dmeta_ff;
    end
  end

  // ========================================================================
  // transaction engine
  wire start = done_apb & PWRITE & s_ctrl & PWDATA[`CTRL_START] & ~busy;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff <= hostport_pkg::H_IDLE;
      idx_ff   <= '0;
      ph_ff    <= '0;
      sel_ff   <= `SEL_OFS_HIGH;
      dout_ff  <= '0;
      doe_ff   <= 1'b0;
      csn_ff   <= 1'b1;
      rdn_ff   <= 1'b1;
      wrn_ff   <= 1'b1;
    end else begin
      unique case (state_ff)
        hostport_pkg::H_IDLE: begin
          idx_ff <= '0;
          if (start) begin
            csn_ff   <= 1'b0;
            state_ff <= hostport_pkg::H_SETUP;
          end
        end
        hostport_pkg::H_SETUP: begin
          ph_ff <= '0;
          if (idx_ff == 16'h0000) begin
            sel_ff   <= `SEL_OFS_HIGH;
            dout_ff  <= ofs_ff[15:8];
            doe_ff   <= 1'b1;
            state_ff <= hostport_pkg::H_LOW;
          end else if (idx_ff == 16'h0001) begin
            sel_ff   <= `SEL_OFS_LOW;
            dout_ff  <= ofs_ff[7:0];
            state_ff <= hostport_pkg::H_LOW;
          end else if (!is_dat) begin
            sel_ff   <= `SEL_BLOCK;
            dout_ff  <= blk_ff;
            state_ff <= hostport_pkg::H_LOW;
          end else if (dir_rd_ff) begin
            sel_ff   <= `SEL_DATA;
            doe_ff   <= 1'b0;
            state_ff <= hostport_pkg::H_LOW;
          end else if (f_out_valid) begin
            sel_ff   <= `SEL_DATA;
            dout_ff  <= f_out_data;
            state_ff <= hostport_pkg::H_LOW;
          end
        end
        hostport_pkg::H_LOW: begin
          wrn_ff <= ~(~is_dat | ~dir_rd_ff) | ph_end;
          rdn_ff <= ~(is_dat & dir_rd_ff) | ph_end;
          if (!ph_end) begin
            ph_ff <= 8'(ph_ff + 1'b1);
          end else if (!eng_push || f_in_ready) begin
            ph_ff    <= '0;
            state_ff <= hostport_pkg::H_HIGH;
          end else begin
            wrn_ff <= wrn_ff;
            rdn_ff <= rdn_ff;
          end
        end
        hostport_pkg::H_HIGH: begin
          if (!ph_end) begin
            ph_ff <= 8'(ph_ff + 1'b1);
          end else begin
            idx_ff   <= 16'(idx_ff + 16'h0001);
            state_ff <= last_byte ? hostport_pkg::H_END : hostport_pkg::H_SETUP;
          end
        end
        hostport_pkg::H_END: begin
          csn_ff   <= 1'b1;
          doe_ff   <= 1'b0;
          state_ff <= hostport_pkg::H_IDLE;
        end
        default: state_ff <= hostport_pkg::H_IDLE;
      endcase
    end
  end

  assign PINS.reg_select     = sel_ff;
  assign PINS.chip_select_n  = csn_ff;
  assign PINS.read_strobe_n  = rdn_ff;
  assign PINS.write_strobe_n = wrn_ff;
  assign PINS.host_dout      = dout_ff;
  assign PINS.host_doe       = doe_ff;
endmodule : port_host
`default_nettype wire

// [src/hostport_consts.svh]
/*
  Constants of the indirect parallel host port: select codes, block-select
  fields, controller register offsets and timing counts.
  Assumes inclusion by bare name from any file of the block.
*/
`ifndef HOSTPORT_CONSTS_SVH
`define HOSTPORT_CONSTS_SVH

// ==========================================================================
// pin-level select codes
`define SEL_OFS_HIGH   2'h0
`define SEL_OFS_LOW    2'h1
`define SEL_BLOCK      2'h2
`define SEL_DATA       2'h3

// ==========================================================================
// block-select fields
`define BLK_SOCK_MSB   7
`define BLK_SOCK_LSB   5
`define BLK_TGT_MSB    4
`define BLK_TGT_LSB    3
`define TGT_COMMON     2'h0
`define SOCK_ZERO      3'h0

// ==========================================================================
// mode straps: pattern 010x selects the parallel port
`define STRAP_PAR      3'h2
`define STRAP_SETTLE   2'h3
// idle pin levels seen by the device synchroniser: strobes and chip select high, register select 00, bus pulled up
`define PIN_IDLE       17'h01CFF

// ==========================================================================
// controller registers, byte addresses on the bus
`define REG_CTRL       8'h00
`define REG_OFFSET     8'h04
`define REG_BLOCK      8'h08
`define REG_COUNT      8'h0C
`define REG_STATUS     8'h10
`define REG_DATA       8'h14
`define CTRL_START     0
`define CTRL_READ      1
`define SETUP_BYTES    16'h0003

// ==========================================================================
// timing: length of each strobe phase in clock cycles (25 ns each)
`define PHASE_CYC      8
`define FIFO_DEPTH     16

`endif

// [src/hostport_pkg.sv]
/*
  Types used by the host end of the indirect parallel host port.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package hostport_pkg;
  typedef enum logic [2:0] {
    H_IDLE,
    H_SETUP,
    H_LOW,
    H_HIGH,
    H_END
  } host_state_e;
  typedef logic [7:0] byte_t;
endpackage : hostport_pkg

// [src/hostport_if.sv]
/*
  Pin bundle between host end and device end of the parallel port.
  Assumes the bench instantiates it and joins both ends; an idle data bus
  floats high as if pulled up.
*/
`timescale 1ns/1ps
`default_nettype none
interface hostport_if;
  logic [1:0] reg_select;
  logic       chip_select_n;
  logic       read_strobe_n;
  logic       write_strobe_n;
  logic [7:0] host_dout;
  logic       host_doe;
  logic [7:0] dev_dout;
  logic       dev_doe;
  logic [7:0] host_data_bus;

  // wire level of the shared data bus from the two output enables
  assign host_data_bus = dev_doe ? dev_dout : (host_doe ? host_dout : 8'hFF);

  modport device (
    input  reg_select,
    input  chip_select_n,
    input  read_strobe_n,
    input  write_strobe_n,
    input  host_data_bus,
    output dev_dout,
    output dev_doe
  );
  modport host (
    output reg_select,
    output chip_select_n,
    output read_strobe_n,
    output write_strobe_n,
    output host_dout,
    output host_doe,
    input  host_data_bus
  );
endinterface : hostport_if
`default_nettype wire

// [src/byte_fifo.sv]
/*
  Synchronous FIFO with valid/ready on both sides, show-ahead output.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  assign in_ready  = (count_ff != DEPTH[AW:0]);
  assign out_valid = (count_ff != '0);
  assign out_data  = mem[rd_ptr_ff];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      wr_ptr_ff <= push ? AW'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
      rd_ptr_ff <= pop ? AW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
      count_ff  <= (AW+1)'(count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end
  end
endmodule : byte_fifo
`default_nettype wire

// [src/port_device.sv]
/*
  Device end of the indirect parallel host port: four host-visible
  registers give indirect byte access to an internal block memory.
  Assumes pins arrive asynchronously and strobe phases last several
  clock cycles so the two-stage synchronisers see each level.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hostport_consts.svh"

// Functional notes
// - straps 010x enable the parallel port
// - internal space reached only via four registers
// - select 00 loads offset high byte
// - select 01 loads offset low byte
// - select 10 loads socket and target byte
// - select 11 moves data at offset
// - host holds chip select low per transaction
// - host pulses write strobe per byte
// - write order: high, low, block, data
// - further data bytes back to back accepted
// - reads use write strobes for setup
// - read: setup, then device drives data
// - repeated read strobes each return a byte
module port_device #(
  parameter int OFS_BITS = 6
) (
  input  wire logic       CLK,
  input  wire logic       RST_N,
  hostport_if.device      PINS,
  input  wire logic [3:0] INTERFACE_STRAP_PINS,
  output logic            PARALLEL_MODE,
  output logic [15:0]     CUR_OFFSET,
  output logic [7:0]      CUR_BLOCK
);
  localparam int SW = 17;
  localparam int MW = 3 + 2 + OFS_BITS;

  // ========================================================================
  // pin synchronisers
  logic [SW-1:0] meta_ff;
  logic [SW-1:0] sync_ff;
  wire  [SW-1:0] pins_raw = {INTERFACE_STRAP_PINS, PINS.chip_select_n,
                             PINS.read_strobe_n, PINS.write_strobe_n,
                             PINS.reg_select, PINS.host_data_bus};

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      // start at the idle levels so no false strobe edge follows reset
      meta_ff <= `PIN_IDLE;
      sync_ff <= `PIN_IDLE;
    end else begin
      meta_ff <= pins_raw;
      sync_ff <= meta_ff;
    end
  end

  wire [3:0] straps_s = sync_ff[16:13];
  wire       cs_n_s   = sync_ff[12];
  wire       rd_n_s   = sync_ff[11];
  wire       wr_n_s   = sync_ff[10];
  wire [1:0] sel_s    = sync_ff[9:8];
  wire [7:0] data_s   = sync_ff[7:0];

  // ========================================================================
  // strap capture after reset release
  logic [1:0] settle_ff;
  logic       par_ff;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      settle_ff <= '0;
      par_ff    <= 1'b0;
    end else if (settle_ff != `STRAP_SETTLE) begin
      settle_ff <= 2'(settle_ff + 1'b1);
      par_ff    <= (straps_s[3:1] == `STRAP_PAR);
    end
  end

  // ========================================================================
  // strobe edges and register decode
  logic       wr_prev_ff;
  logic       rd_prev_ff;
  logic [7:0] ofs_hi_ff;
  logic [7:0] ofs_lo_ff;
  logic [7:0] blk_ff;

  wire        active   = par_ff & ~cs_n_s;
  wire        wr_done  = active & wr_n_s & ~wr_prev_ff;
  wire        rd_start = active & ~rd_n_s & rd_prev_ff;
  wire        rd_done  = active & rd_n_s & ~rd_prev_ff;
  wire        sel_hi   = (sel_s == `SEL_OFS_HIGH);
  wire        sel_lo   = (sel_s == `SEL_OFS_LOW);
  wire        sel_blk  = (sel_s == `SEL_BLOCK);
  wire        sel_dat  = (sel_s == `SEL_DATA);
  wire [15:0] offset   = {ofs_hi_ff, ofs_lo_ff};
  wire [15:0] ofs_inc  = 16'(offset + 16'h0001);
  wire [2:0]  sock     = blk_ff[`BLK_SOCK_MSB:`BLK_SOCK_LSB];
  wire [1:0]  target   = blk_ff[`BLK_TGT_MSB:`BLK_TGT_LSB];
  // common registers exist only with socket 0; other codes are reserved
  wire        blk_ok   = (target != `TGT_COMMON) | (sock == `SOCK_ZERO);
  wire [MW-1:0] mem_idx = {sock, target, ofs_lo_ff[OFS_BITS-1:0]};
  wire        mem_wr   = wr_done & sel_dat & blk_ok;
  wire        dat_step = (wr_done | rd_done) & sel_dat;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_prev_ff <= 1'b1;
      rd_prev_ff <= 1'b1;
    end else begin
      wr_prev_ff <= wr_n_s;
      rd_prev_ff <= rd_n_s;
    end
  end

  // ========================================================================
  // indirect offset and block select
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ofs_hi_ff <= '0;
      ofs_lo_ff <= '0;
      blk_ff    <= '0;
    end else if (dat_step) begin
      {ofs_hi_ff, ofs_lo_ff} <= ofs_inc;
    end else if (wr_done) begin
      if (sel_hi) begin
        ofs_hi_ff <= data_s;
      end
      if (sel_lo) begin
        ofs_lo_ff <= data_s;
      end
      if (sel_blk) begin
        blk_ff <= data_s;
      end
    end
  end

  // ========================================================================
  // internal block memory, reached only through the data window
  logic [7:0] mem [2**MW];

  always_ff @(posedge CLK) begin
    if (mem_wr) begin
      mem[mem_idx] <= data_s;
    end
  end

  // ========================================================================
  // read path and bus drive
  logic [7:0] dout_ff;
  logic       doe_ff;
  wire  [7:0] win_data = blk_ok ? mem[mem_idx] : 8'h00;
  wire  [7:0] rd_mux   = sel_hi  ? ofs_hi_ff :
                         sel_lo  ? ofs_lo_ff :
                         sel_blk ? blk_ff    : win_data;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dout_ff <= '0;
      doe_ff  <= 1'b0;
    end else begin
      if (rd_start) begin
        dout_ff <= rd_mux;
      end
      doe_ff <= active & ~rd_n_s & ~rd_prev_ff;
    end
  end

  assign PINS.dev_dout = dout_ff;
  assign PINS.dev_doe  = doe_ff;

  // ========================================================================
  // user-side status
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PARALLEL_MODE <= 1'b0;
      CUR_OFFSET    <= '0;
      CUR_BLOCK     <= '0;
    end else begin
      PARALLEL_MODE <= par_ff;
      CUR_OFFSET    <= offset;
      CUR_BLOCK     <= blk_ff;
    end
  end
endmodule : port_device
`default_nettype wire

// [sim/hostport_properties.sv]
/*
  Pin-level checker for the parallel host port, both ends joined.
  Assumes the bench wires every input to the shared pin bundle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hostport_consts.svh"
module hostport_properties (
  input wire logic       CLK,
  input wire logic       RST_N,
  input wire logic [1:0] reg_select,
  input wire logic       chip_select_n,
  input wire logic       read_strobe_n,
  input wire logic       write_strobe_n,
  input wire logic [7:0] host_dout,
  input wire logic       host_doe,
  input wire logic [7:0] dev_dout,
  input wire logic       dev_doe,
  input wire logic [7:0] host_data_bus
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // ==========================================================================
  // transaction steps
  sequence txn_open;
    $fell(chip_select_n);
  endsequence
  sequence rd_open;
    $fell(read_strobe_n) && !chip_select_n;
  endsequence
  sequence wr_open;
    $fell(write_strobe_n);
  endsequence

  // ==========================================================================
  // pin rules
  chk_first_high: assert property (
    txn_open |-> ##[1:3] ($fell(write_strobe_n) && reg_select == `SEL_OFS_HIGH))
    else $error("first strobe of a transaction not on offset high");
  chk_wr_len: assert property (wr_open |-> (!write_strobe_n)[*7])
    else $error("write strobe low phase too short");
  chk_rd_sel: assert property (!read_strobe_n |-> reg_select == `SEL_DATA)
    else $error("read strobe outside data select");
  chk_rd_answer: assert property (rd_open |-> ##[2:7] dev_doe)
    else $error("device did not answer a read strobe");
  chk_doe_cause: assert property ($rose(dev_doe) |-> !read_strobe_n && !chip_select_n)
    else $error("device drove the bus without a read");
  chk_doe_release: assert property (read_strobe_n [*6] |-> !dev_doe)
    else $error("device kept driving after the read");
  chk_no_fight: assert property (!(dev_doe && host_doe))
    else $error("both ends drive the data bus");
  chk_strobe_cs: assert property (!read_strobe_n || !write_strobe_n |-> !chip_select_n)
    else $error("strobe outside chip select");
  chk_dout_hold: assert property (dev_doe && $past(dev_doe) |-> $stable(dev_dout))
    else $error("read byte changed while driven");
  chk_cs_close: assert property (
    $rose(chip_select_n) |-> write_strobe_n && read_strobe_n ##1 !host_doe)
    else $error("transaction closed with bus still busy");
endmodule : hostport_properties
`default_nettype wire

// [sim/indirect_parallel_host_port_tb_top.sv]
/*
  Self-checking bench: APB drives the host end, the device end answers.
  Assumes the two ends, the pin interface and the constants header.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hostport_consts.svh"
module indirect_parallel_host_port_tb_top;
  logic        clk = 1'b0;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        par_mode;
  logic [15:0] cur_ofs;
  logic [7:0]  cur_blk;
  logic [31:0] rd;
  logic [3:0]  straps = 4'h5;
  logic        err;
  int          n_fail = 0;
  int          comparisons = 0;
  int          cycles = 0;

  // ==========================================================================
  // the two ends and the checker
  hostport_if pins_i ();
  port_host #(.PHASE_CYCLES(`PHASE_CYC), .FIFO_DEPTH(`FIFO_DEPTH)) port_host_i (
    .CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .PINS(pins_i.host));
  port_device #(.OFS_BITS(6)) port_device_i (
    .CLK(clk), .RST_N(rst_n), .PINS(pins_i.device), .INTERFACE_STRAP_PINS(straps),
    .PARALLEL_MODE(par_mode), .CUR_OFFSET(cur_ofs), .CUR_BLOCK(cur_blk));
  hostport_properties hostport_properties_i (
    .CLK(clk), .RST_N(rst_n), .reg_select(pins_i.reg_select),
    .chip_select_n(pins_i.chip_select_n), .read_strobe_n(pins_i.read_strobe_n),
    .write_strobe_n(pins_i.write_strobe_n), .host_dout(pins_i.host_dout),
    .host_doe(pins_i.host_doe), .dev_dout(pins_i.dev_dout), .dev_doe(pins_i.dev_doe),
    .host_data_bus(pins_i.host_data_bus));

  always #12.5 clk = ~clk;

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  // ==========================================================================
  // bus and compare tasks
  task automatic end_sim;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // take the answer at the rising edge where pready is sampled high
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  task automatic go(input logic dir, input logic [15:0] ofs, input logic [7:0] blk,
                    input logic [15:0] cnt);
    wr(`REG_OFFSET, {16'h0, ofs});
    wr(`REG_BLOCK, {24'h0, blk});
    wr(`REG_COUNT, {16'h0, cnt});
    wr(`REG_CTRL, {30'h0, dir, 1'b1});
    rd = 32'h1;
    while (rd[0] !== 1'b0) apb(1'b0, `REG_STATUS, 32'h0);
  endtask : go

  // ==========================================================================
  // scenarios
  task automatic t_refuse;
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
  endtask : t_refuse

  task automatic t_setup_only;
    wr(`REG_CTRL, 32'h0);
    go(1'b0, 16'hA53C, 8'h08, 16'h0);
    chk({16'h0, cur_ofs}, 32'h0000A53C);
    chk({24'h0, cur_blk}, 32'h00000008);
  endtask : t_setup_only

  task automatic t_write_burst;
    wr(`REG_CTRL, 32'h0);
    for (int i = 0; i < 16; i++) wr(`REG_DATA, 32'h30 + i);
    rdchk(`REG_STATUS, 32'h4);
    go(1'b0, 16'h0010, 8'h10, 16'h10);
    chk({16'h0, cur_ofs}, 32'h20);
    rdchk(`REG_STATUS, 32'h2);
  endtask : t_write_burst

  task automatic t_read_burst;
    wr(`REG_CTRL, 32'h2);
    go(1'b1, 16'h0010, 8'h10, 16'h10);
    rdchk(`REG_STATUS, 32'h4);
    for (int i = 0; i < 16; i++) rdchk(`REG_DATA, 32'h30 + i);
    rdchk(`REG_STATUS, 32'h2);
  endtask : t_read_burst

  task automatic t_blocks;
    // target 00 with socket 5 is reserved: write dropped, read gives 0
    for (int t = 0; t < 4; t++) begin
      wr(`REG_CTRL, 32'h0);
      wr(`REG_DATA, 32'hA0 + t);
      go(1'b0, 16'h0003, {3'h5, t[1:0], 3'h0}, 16'h1);
      chk({16'h0, cur_ofs}, 32'h4);
    end
    for (int t = 0; t < 4; t++) begin
      wr(`REG_CTRL, 32'h2);
      go(1'b1, 16'h0003, {3'h5, t[1:0], 3'h0}, 16'h1);
      rdchk(`REG_DATA, (t == 0) ? 32'h0 : 32'hA0 + t);
    end
  endtask : t_blocks

  task automatic t_strap_off;
    // straps 011x leave the port off: strobes must change nothing
    straps <= 4'h6;
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk({31'h0, par_mode}, 32'h0);
    go(1'b0, 16'h1234, 8'h08, 16'h0);
    chk({16'h0, cur_ofs}, 32'h0);
  endtask : t_strap_off

  // ==========================================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk({31'h0, par_mode}, 32'h1);
    t_refuse();
    t_setup_only();
    t_write_burst();
    t_read_burst();
    t_blocks();
    t_strap_off();
    end_sim();
  end
endmodule : indirect_parallel_host_port_tb_top
`default_nettype wire
